// ---- logic/multicast_latency_limiter.sv ----
`timescale 1ns/10ps
// How it works
// - low byte of version register reads a fixed version; writes ignored
// - timer measures wait of oldest copy at head of broadcast buffer
// - limit of zero disables supervision: no expiry, discard or report
// - expiry period is limit times 6.4 ns
// - on expiry every copy in the broadcast buffer is discarded
// - on expiry partly transferred copies are dropped too
// - on expiry raise interrupt or port-write as configured
// - removal bit set: expiry excludes port from later multicast
// - removal bit clear: port keeps participating after expiry
// - exclusion holds until software clears the expired error
// - expiry sets the port's flag in the expired status register
// - largest limit gives the longest timeout without wrapping
module multicast_latency_limiter import mc_lat_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire buf_status_t buf_status,
   output buf_control_t buf_control,
   output logic irq
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      apb_state_t ap;
      logic pready;
      logic slverr;
      logic [DATA_W-1:0] rdata;
      logic removal_en;
      logic [LIMIT_W-1:0] limit;
      logic expired;
      logic expired_mask;
      logic pw_en;
      logic excluded;
      logic flush;
      logic drop;
      logic pw_req;
      logic irq;
   } lim_state_t;

   lim_state_t q, d;
   logic expiry;

   // ----------------------------------------------------------------
   // head-of-line timer
   // ----------------------------------------------------------------
   mc_head_timer #(
      .LIM_W(LIMIT_W)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .head_valid(buf_status.head_valid),
      .head_advance(buf_status.head_advance),
      .limit(q.limit),
      .fired(expiry)
   );

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      is_mapped = (a == ADR_VERSION) || (a == ADR_LIMIT) || (a == ADR_STATUS) ||
                  (a == ADR_MASK) || (a == ADR_REPORT);
   endfunction

   function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a, input lim_state_t s);
      logic [DATA_W-1:0] w;
      w = ZERO_WORD;
      case (a)
         ADR_VERSION: w[VERSION_W-1:0] = INTERFACE_VERSION;
         ADR_LIMIT: begin
            w[REMOVAL_BIT] = s.removal_en;
            w[LIMIT_LSB +: LIMIT_W] = s.limit;
         end
         ADR_STATUS: w[EXPIRED_BIT] = s.expired;
         ADR_MASK: w[EXPIRED_BIT] = s.expired_mask;
         ADR_REPORT: w[PW_EN_BIT] = s.pw_en;
         default: w = ZERO_WORD;
      endcase
      read_word = w;
   endfunction

   logic access;
   logic wr_go;
   logic status_clear;
   assign access = psel && penable;
   assign wr_go = access && q.pready && pwrite && is_mapped(paddr);
   assign status_clear = wr_go && paddr == ADR_STATUS && pwdata[EXPIRED_BIT];

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      d.flush = 1'b0;
      d.drop = 1'b0;
      d.pw_req = 1'b0;
      // one wait state: answer is registered so every output is a flop
      case (q.ap)
         AP_IDLE: begin
            if (access) begin
               d.ap = AP_DONE;
               d.pready = 1'b1;
               d.slverr = !is_mapped(paddr);
               d.rdata = pwrite ? ZERO_WORD : read_word(paddr, q);
            end
         end
         AP_DONE: begin
            d.ap = AP_IDLE;
            d.pready = 1'b0;
            d.slverr = 1'b0;
         end
         default: begin
            d.ap = AP_IDLE;
            d.pready = 1'b0;
            d.slverr = 1'b0;
         end
      endcase
      if (wr_go) begin
         case (paddr)
            ADR_LIMIT: begin
               d.removal_en = pwdata[REMOVAL_BIT];
               d.limit = pwdata[LIMIT_LSB +: LIMIT_W];
            end
            ADR_MASK: d.expired_mask = pwdata[EXPIRED_BIT];
            ADR_REPORT: d.pw_en = pwdata[PW_EN_BIT];
            default: d.limit = q.limit; // version is read only
         endcase
      end
      if (status_clear) begin
         // clearing the error is the recovery step
         d.expired = 1'b0;
         d.excluded = 1'b0;
      end
      // expiry after the clear: a same-cycle event is never lost
      if (expiry) begin
         d.expired = 1'b1;
         d.flush = 1'b1;
         d.drop = 1'b1;
         d.pw_req = q.pw_en;
         if (q.removal_en) begin
            d.excluded = 1'b1;
         end
         // removal disabled leaves membership untouched
      end
      d.irq = d.expired && d.expired_mask;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.ap <= AP_IDLE;
         q.limit <= LIMIT_RESET;
      end else if (ce) begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign prdata = q.rdata;
   assign pready = q.pready;
   assign pslverr = q.slverr;
   assign irq = q.irq;
   // one driver for the whole carrier: flush, drop, excluded, port-write request
   assign buf_control = {q.flush, q.drop, q.excluded, q.pw_req};

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_version_fixed: assert property (@(posedge pclk) disable iff (!presetn)
      ce && q.ap == AP_IDLE && access && !pwrite && paddr == ADR_VERSION
      |=> prdata == {{(DATA_W-VERSION_W){1'b0}}, INTERFACE_VERSION} && pready)
      else $error("version read wrong");
   a_flush_on_expiry: assert property (@(posedge pclk) disable iff (!presetn)
      ce && expiry |=> buf_control.flush_buffer ##1 (!ce || !buf_control.flush_buffer))
      else $error("buffer not flushed on expiry");
   a_drop_partial: assert property (@(posedge pclk) disable iff (!presetn)
      buf_control.drop_partial |-> buf_control.flush_buffer && $past(expiry))
      else $error("partial drop without expiry");
   a_report_pw: assert property (@(posedge pclk) disable iff (!presetn)
      ce && expiry |=> buf_control.port_write_req == $past(q.pw_en) && irq == (q.expired_mask))
      else $error("error report wrong");
   a_removal_excl: assert property (@(posedge pclk) disable iff (!presetn)
      ce && expiry && q.removal_en |=> buf_control.port_excluded)
      else $error("port not excluded");
   a_keep_member: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !q.excluded && !(expiry && q.removal_en) |=> !buf_control.port_excluded)
      else $error("port excluded without removal");
   a_excl_holds: assert property (@(posedge pclk) disable iff (!presetn)
      ce && q.excluded && !status_clear |=> buf_control.port_excluded)
      else $error("exclusion lost without recovery");
   a_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      ce && expiry |=> q.expired ##1 (q.expired || $past(status_clear)))
      else $error("expired flag not recorded");

   c_expiry: cover property (@(posedge pclk) disable iff (!presetn)
      expiry ##1 buf_control.flush_buffer);
   c_recover: cover property (@(posedge pclk) disable iff (!presetn)
      q.excluded ##1 !q.excluded);
   c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
      pready && pslverr);
   c_set_clear_race: cover property (@(posedge pclk) disable iff (!presetn)
      expiry && status_clear);

endmodule

// ---- logic/mc_lat_pkg.sv ----
package mc_lat_pkg;

   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;

   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADR_VERSION = 20'h1b000;
   localparam logic [ADDR_W-1:0] ADR_LIMIT = 20'h1b004;
   localparam logic [ADDR_W-1:0] ADR_STATUS = 20'h1b040;
   localparam logic [ADDR_W-1:0] ADR_MASK = 20'h1b044;
   localparam logic [ADDR_W-1:0] ADR_REPORT = 20'h1b048;

   // ----------------------------------------------------------------
   // field layout and reset values
   // ----------------------------------------------------------------
   localparam int LIMIT_W = 24;
   localparam int LIMIT_LSB = 0;
   localparam int REMOVAL_BIT = 31;
   localparam int VERSION_W = 8;
   localparam int EXPIRED_BIT = 0;
   localparam int PW_EN_BIT = 0;
   // arbitrary neutral value, not a real part's version code
   localparam logic [VERSION_W-1:0] INTERFACE_VERSION = 8'h5a;
   localparam logic [LIMIT_W-1:0] LIMIT_RESET = 24'h000000;
   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;

   // ----------------------------------------------------------------
   // timing: elapsed time kept in units of 1.6 ns
   // ----------------------------------------------------------------
   localparam int TICK_PS = 6400;
   localparam int CLK_PERIOD_PS = 8000;
   localparam int UNIT_PS = 1600;
   localparam int TICK_UNITS = TICK_PS / UNIT_PS;
   localparam int STEP_UNITS = CLK_PERIOD_PS / UNIT_PS;

   // ----------------------------------------------------------------
   // carriers to and from the broadcast buffer
   // ----------------------------------------------------------------
   typedef struct packed {
      logic head_valid;
      logic head_advance;
   } buf_status_t;

   typedef struct packed {
      logic flush_buffer;
      logic drop_partial;
      logic port_excluded;
      logic port_write_req;
   } buf_control_t;

   typedef enum logic {AP_IDLE, AP_DONE} apb_state_t;

endpackage

// ---- logic/mc_head_timer.sv ----
`timescale 1ns/10ps
module mc_head_timer import mc_lat_pkg::*; #(
   parameter int LIM_W = LIMIT_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic head_valid,
   input wire logic head_advance,
   input wire logic [LIM_W-1:0] limit,
   output logic fired
);

   localparam int CNT_W = LIM_W + 4;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic armed;
      logic fired;
   } timer_state_t;

   timer_state_t q, d;

   // ----------------------------------------------------------------
   // elapsed time against limit
   // ----------------------------------------------------------------
   // full width product so the largest limit cannot wrap
   function automatic logic [CNT_W-1:0] to_units(input logic [LIM_W-1:0] l);
      to_units = CNT_W'(l) * CNT_W'(TICK_UNITS);
   endfunction

   logic [CNT_W-1:0] next_cnt;
   assign next_cnt = q.cnt + CNT_W'(STEP_UNITS);

   always_comb begin
      d = q;
      d.fired = 1'b0;
      if (!head_valid || head_advance || limit == '0) begin
         // restart on a new head or empty buffer; zero limit parks it
         d.cnt = '0;
         d.armed = 1'b1;
      end else if (q.armed) begin
         // oldest copy waited limit x 6.4 ns
         if (next_cnt >= to_units(limit)) begin
            d.fired = 1'b1;
            d.armed = 1'b0;
         end else begin
            d.cnt = next_cnt;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign fired = q.fired;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_zero_disables: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(q.fired) |-> $past(limit) != '0)
      else $error("expiry while supervision disabled");
   a_period_reached: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(q.fired) |-> $past(next_cnt) >= $past(to_units(limit)))
      else $error("expiry before limit period");
   a_restart_empty: assert property (@(posedge pclk) disable iff (!presetn)
      ce && (!head_valid || head_advance) |=> q.cnt == '0 && !q.fired)
      else $error("timer not restarted");

endmodule

// ---- bench/multicast_latency_limiter_test.sv ----
`timescale 1ns/10ps
module multicast_latency_limiter_test import mc_lat_pkg::*;;
   // ------------------------------------------------
   // signals and notes of expected results
   // ------------------------------------------------
   typedef struct packed {logic [DATA_W-1:0] data; logic err;} rd_note_t;
   typedef struct packed {buf_control_t ctl; logic irq; logic [15:0] lo; logic [15:0] hi;} fire_note_t;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata;
   buf_status_t buf_status;
   buf_control_t buf_control;
   int mismatches, comparisons, cyc, t0, seed, k, i;
   rd_note_t rq[$];
   fire_note_t fq[$];
   rd_note_t rn;
   fire_note_t fn;

   multicast_latency_limiter u_multicast_latency_limiter (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .buf_status(buf_status), .buf_control(buf_control), .irq(irq));

   initial begin
      pclk = 0;
      forever #4 pclk = ~pclk;
   end

   // ------------------------------------------------
   // shared tasks
   // ------------------------------------------------
   task check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task end_of_test;
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // request held until pready is sampled high
   task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
            input logic [DATA_W-1:0] exp, input logic err);
      rq.push_back({exp, err});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // one head copy left waiting until it expires
   task expire(input logic [23:0] lim, input logic rem, input logic msk, input logic pw);
      int n;
      n = (4 * lim + 4) / 5;
      apb(1'b1, ADR_LIMIT, {rem, 7'h00, lim}, ZERO_WORD, 1'b0);
      apb(1'b1, ADR_MASK, {31'h0, msk}, ZERO_WORD, 1'b0);
      apb(1'b1, ADR_REPORT, {31'h0, pw}, ZERO_WORD, 1'b0);
      fq.push_back({{1'b1, 1'b1, rem, pw}, msk, 16'(n + 1), 16'(n + 3)});
      buf_status.head_valid <= 1'b1;
      t0 = cyc;
      repeat (n + 12) @(posedge pclk);
      buf_status.head_valid <= 1'b0;
      @(posedge pclk);
      check(fq.size(), 0);
      check({31'h0, buf_control.port_excluded}, {31'h0, rem});
      apb(1'b0, ADR_STATUS, ZERO_WORD, 32'h1, 1'b0);
      apb(1'b1, ADR_STATUS, 32'h1, ZERO_WORD, 1'b0);
      check({30'h0, buf_control.port_excluded, irq}, 32'h0);
   endtask

   // ------------------------------------------------
   // watcher: takes the oldest note per result
   // ------------------------------------------------
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      // ceiling well above the 1300 or so cycles at most that the run needs
      if (cyc > 20000) begin
         mismatches++;
         end_of_test;
      end
      if (psel && penable && pready === 1'b1) begin
         if (rq.size() == 0) check(32'h1, 32'h0);
         else begin
            rn = rq.pop_front();
            check(prdata, rn.data);
            check({31'h0, pslverr}, {31'h0, rn.err});
         end
      end
      if (buf_control.flush_buffer === 1'b1) begin
         if (fq.size() == 0) check(32'h1, 32'h0);
         else begin
            fn = fq.pop_front();
            check({27'h0, buf_control, irq}, {27'h0, fn.ctl, fn.irq});
            check({31'h0, (cyc - t0 >= fn.lo) && (cyc - t0 <= fn.hi)}, 32'h1);
         end
      end
   end

   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      seed = 32'h3e4f78bf;
      {presetn, psel, penable, pwrite, paddr, pwdata, buf_status, cyc, t0} = '0;
      ce = 1'b1;
      mismatches = 0;
      comparisons = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, ADR_VERSION, ZERO_WORD, {24'h0, INTERFACE_VERSION}, 1'b0);
      apb(1'b0, ADR_LIMIT, ZERO_WORD, ZERO_WORD, 1'b0);
      apb(1'b0, ADR_MASK, ZERO_WORD, ZERO_WORD, 1'b0);
      apb(1'b1, ADR_VERSION, 32'hffffffff, ZERO_WORD, 1'b0);
      apb(1'b0, ADR_VERSION, ZERO_WORD, {24'h0, INTERFACE_VERSION}, 1'b0);
      apb(1'b1, ADR_LIMIT, 32'hffffffff, ZERO_WORD, 1'b0);
      apb(1'b0, ADR_LIMIT, ZERO_WORD, 32'h80ffffff, 1'b0);
      apb(1'b0, 20'h1b008, ZERO_WORD, ZERO_WORD, 1'b1);
      apb(1'b1, 20'h1b006, 32'h1, ZERO_WORD, 1'b1);
      // zero limit: a head left waiting long must never fire
      apb(1'b1, ADR_LIMIT, 32'h80000000, ZERO_WORD, 1'b0);
      buf_status.head_valid <= 1'b1;
      repeat (300) @(posedge pclk);
      buf_status.head_valid <= 1'b0;
      apb(1'b0, ADR_STATUS, ZERO_WORD, ZERO_WORD, 1'b0);
      // restart on new head and on empty keeps a limit of 10 from firing
      apb(1'b1, ADR_LIMIT, 32'h0000000a, ZERO_WORD, 1'b0);
      for (i = 0; i < 80; i++) begin
         @(posedge pclk);
         buf_status.head_advance <= (i < 40) && (i % 6 == 5);
         buf_status.head_valid <= (i < 40) || (i % 7 != 6);
      end
      @(posedge pclk);
      buf_status <= '0;
      @(posedge pclk);
      expire(24'h000001, 1'b1, 1'b1, 1'b1);
      expire(24'h000005, 1'b0, 1'b1, 1'b0);
      // mask gates the level output while the status bit stays set
      expire(24'h000003, 1'b0, 1'b0, 1'b1);
      for (k = 0; k < 8; k++)
         expire(24'(($random(seed) & 32'h3f) + 1), k[0], k[1], k[2]);
      // frozen enable: a waiting head must not fire while ce is low
      apb(1'b1, ADR_LIMIT, 32'h00000001, ZERO_WORD, 1'b0);
      ce <= 1'b0;
      buf_status.head_valid <= 1'b1;
      repeat (20) @(posedge pclk);
      ce <= 1'b1;
      buf_status.head_valid <= 1'b0;
      @(posedge pclk);
      // mid-run reset returns the registers to their reset values
      apb(1'b1, ADR_LIMIT, 32'h80000021, ZERO_WORD, 1'b0);
      apb(1'b1, ADR_REPORT, 32'h1, ZERO_WORD, 1'b0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, ADR_LIMIT, ZERO_WORD, ZERO_WORD, 1'b0);
      apb(1'b0, ADR_REPORT, ZERO_WORD, ZERO_WORD, 1'b0);
      check(rq.size(), 0);
      end_of_test;
   end
endmodule
